// ---- inc/rmsu_pkg.sv ----
// How it works
// - Current rms per phase comes from the current waveform samples, kept unsigned 24-bit.
// - One current rms LSB equals one current sample LSB.
// - Each current rms result is refreshed once every 12 master clocks.
// - Full-scale sine peaking near 2,684,354 gives about 1,898,124 rms.
// - In active power mode 1 or 2, current rms scales by sqrt(1+gain/4096).
// - Power gain settings are 12-bit signed, 800h most negative, 7FFh most positive.
// - Each phase has a 12-bit signed current rms offset setting.
// - Corrected current rms is sqrt(rms squared plus offset times 32768).
// - Voltage rms is computed from voltage samples after gain scaling.
// - Voltage gain scales voltage samples over plus or minus 50 percent.
// - Voltage rms per phase is held as an unsigned 24-bit value.
// - About 256 voltage rms LSBs equal one voltage sample LSB.
// - Each voltage rms result is refreshed once every 12 master clocks.
// - Full-scale 60 Hz voltage gives about 1C35C4h in the voltage rms register.
// - Rms is the square root of the low-pass filtered squared samples.
// - Voltage rms gets the 12-bit signed offset times 64 added.
// - In apparent power mode 1 or 2, voltage scales by 1+gain/4096.
package rmsu_pkg;

  localparam int unsigned CUR_W       = 24;
  localparam int unsigned VOLT_W      = 16;
  localparam int unsigned RMS_W       = 24;
  localparam int unsigned SQ_W        = 48;
  localparam int unsigned SET_W       = 12;
  localparam int unsigned TRIM_W      = 16;
  localparam int unsigned MODE_W      = 2;
  localparam int unsigned IDX_W       = 6;
  localparam int unsigned SLOT_W      = 4;

  localparam logic [SLOT_W-1:0] UPDATE_DIV_M1 = 4'hB;
  localparam int unsigned GAIN_SH     = 12;
  localparam int unsigned CUR_OFF_SH  = 15;
  localparam int unsigned VOLT_OFF_SH = 6;
  localparam int unsigned VOLT_RMS_SH = 16;
  localparam int unsigned LPF_SH      = 6;

  localparam logic [IDX_W-1:0] IDX_IRMS  = 6'h10;
  localparam logic [IDX_W-1:0] IDX_VRMS  = 6'h14;
  localparam logic [IDX_W-1:0] IDX_PGAIN = 6'h18;
  localparam logic [IDX_W-1:0] IDX_IOFF  = 6'h1C;
  localparam logic [IDX_W-1:0] IDX_VMULT = 6'h20;
  localparam logic [IDX_W-1:0] IDX_VOFF  = 6'h24;
  localparam logic [IDX_W-1:0] IDX_AMODE = 6'h28;
  localparam logic [IDX_W-1:0] IDX_VMODE = 6'h29;
  localparam logic [IDX_W-1:0] IDX_TRIM  = 6'h3D;

  localparam logic [SET_W-1:0]  RST_SET  = 12'h000;
  localparam logic [TRIM_W-1:0] RST_TRIM = 16'h0000;
  localparam logic [MODE_W-1:0] RST_MODE = 2'h0;
  localparam logic [RMS_W-1:0]  RST_RMS  = 24'h000000;

  typedef enum logic [3:0] {
    RMSU_K_NONE, RMSU_K_IRMS, RMSU_K_VRMS, RMSU_K_PGAIN, RMSU_K_IOFF,
    RMSU_K_VMULT, RMSU_K_VOFF, RMSU_K_AMODE, RMSU_K_VMODE, RMSU_K_TRIM
  } rmsu_kind_t;

  typedef struct packed {
    rmsu_kind_t kind;
    logic [1:0] ph;
  } rmsu_dec_t;

  typedef struct packed {
    logic                       valid;
    logic [2:0][CUR_W-1:0]      cur;
    logic [2:0][VOLT_W-1:0]     volt;
  } rmsu_samples_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } rmsu_ahb_req_t;

endpackage

// ---- logic/rmsu_top.sv ----
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module rmsu_top (
  // Clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  arst_n_i,
  // Sample streams from the converter filters, same clock
  input  wire rmsu_pkg::rmsu_samples_t smp_i,
  // AHB-Lite slave
  input  wire rmsu_pkg::rmsu_ahb_req_t ahb_i,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  output logic [31:0]                hrdata_o
);
  import rmsu_pkg::*;

  logic rst_meta_reg;
  logic rst_n_reg;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  function automatic logic [RMS_W-1:0] isqrt(input logic [SQ_W-1:0] x);
    logic [RMS_W-1:0] r;
    logic [RMS_W-1:0] t;
    r = '0;
    for (int b = RMS_W - 1; b >= 0; b--) begin
      t = r | (24'h000001 << b);
      if ({24'h000000, t} * {24'h000000, t} <= x) begin
        r = t;
      end
    end
    return r;
  endfunction

  function automatic rmsu_dec_t decode(input logic [IDX_W-1:0] idx);
    rmsu_dec_t d;
    d.kind = RMSU_K_NONE;
    d.ph   = 2'h0;
    if (idx >= IDX_IRMS && idx < IDX_IRMS + 6'h03) begin
      d.kind = RMSU_K_IRMS;
      d.ph   = 2'(idx - IDX_IRMS);
    end else if (idx >= IDX_VRMS && idx < IDX_VRMS + 6'h03) begin
      d.kind = RMSU_K_VRMS;
      d.ph   = 2'(idx - IDX_VRMS);
    end else if (idx >= IDX_PGAIN && idx < IDX_PGAIN + 6'h03) begin
      d.kind = RMSU_K_PGAIN;
      d.ph   = 2'(idx - IDX_PGAIN);
    end else if (idx >= IDX_IOFF && idx < IDX_IOFF + 6'h03) begin
      d.kind = RMSU_K_IOFF;
      d.ph   = 2'(idx - IDX_IOFF);
    end else if (idx >= IDX_VMULT && idx < IDX_VMULT + 6'h03) begin
      d.kind = RMSU_K_VMULT;
      d.ph   = 2'(idx - IDX_VMULT);
    end else if (idx >= IDX_VOFF && idx < IDX_VOFF + 6'h03) begin
      d.kind = RMSU_K_VOFF;
      d.ph   = 2'(idx - IDX_VOFF);
    end else if (idx == IDX_AMODE) begin
      d.kind = RMSU_K_AMODE;
    end else if (idx == IDX_VMODE) begin
      d.kind = RMSU_K_VMODE;
    end else if (idx == IDX_TRIM) begin
      d.kind = RMSU_K_TRIM;
    end
    return d;
  endfunction

  // Settings and results.
  logic [SET_W-1:0]  pgain_reg [3];
  logic [SET_W-1:0]  ioff_reg  [3];
  logic [SET_W-1:0]  vmult_reg [3];
  logic [SET_W-1:0]  voff_reg  [3];
  logic [RMS_W-1:0]  irms_reg  [3];
  logic [RMS_W-1:0]  vrms_reg  [3];
  logic [TRIM_W-1:0] trim_reg;
  logic [MODE_W-1:0] amode_reg;
  logic [MODE_W-1:0] vmode_reg;
  logic              a_gain_on;
  logic              v_gain_on;

  assign a_gain_on = (amode_reg == 2'h1) || (amode_reg == 2'h2);
  assign v_gain_on = (vmode_reg == 2'h1) || (vmode_reg == 2'h2);

  // Bus slave: zero wait states, reads are fetched at the address phase.
  logic             addr_ok;
  logic [IDX_W-1:0] req_idx;
  rmsu_dec_t        rd_dec;
  rmsu_dec_t        wr_dec;
  logic             wr_pend_reg;
  logic [IDX_W-1:0] wr_idx_reg;
  logic [31:0]      rd_val;

  assign addr_ok = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;
  assign req_idx = ahb_i.haddr[IDX_W+1:2];
  assign rd_dec  = decode(req_idx);
  assign wr_dec  = decode(wr_idx_reg);

  always_comb begin
    rd_val = 32'h00000000;
    case (rd_dec.kind)
      RMSU_K_IRMS:  rd_val = {8'h00, irms_reg[rd_dec.ph]};
      RMSU_K_VRMS:  rd_val = {8'h00, vrms_reg[rd_dec.ph]};
      RMSU_K_PGAIN: rd_val = {20'h00000, pgain_reg[rd_dec.ph]};
      RMSU_K_IOFF:  rd_val = {20'h00000, ioff_reg[rd_dec.ph]};
      RMSU_K_VMULT: rd_val = {20'h00000, vmult_reg[rd_dec.ph]};
      RMSU_K_VOFF:  rd_val = {20'h00000, voff_reg[rd_dec.ph]};
      RMSU_K_AMODE: rd_val = {30'h00000000, amode_reg};
      RMSU_K_VMODE: rd_val = {30'h00000000, vmode_reg};
      RMSU_K_TRIM:  rd_val = {16'h0000, trim_reg};
      default:      rd_val = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
      hrdata_o    <= 32'h00000000;
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 6'h00;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      wr_pend_reg <= addr_ok && ahb_i.hwrite;
      if (addr_ok) begin
        wr_idx_reg <= req_idx;
        hrdata_o   <= ahb_i.hwrite ? 32'h00000000 : rd_val;
      end
    end
  end

  // Calibration writes land at the end of the data phase.
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      for (int p = 0; p < 3; p++) begin
        pgain_reg[p] <= RST_SET;
        ioff_reg[p]  <= RST_SET;
        vmult_reg[p] <= RST_SET;
        voff_reg[p]  <= RST_SET;
      end
      trim_reg  <= RST_TRIM;
      amode_reg <= RST_MODE;
      vmode_reg <= RST_MODE;
    end else if (wr_pend_reg) begin
      case (wr_dec.kind)
        RMSU_K_PGAIN: pgain_reg[wr_dec.ph] <= ahb_i.hwdata[SET_W-1:0];
        RMSU_K_IOFF:  ioff_reg[wr_dec.ph]  <= ahb_i.hwdata[SET_W-1:0];
        RMSU_K_VMULT: vmult_reg[wr_dec.ph] <= ahb_i.hwdata[SET_W-1:0];
        RMSU_K_VOFF:  voff_reg[wr_dec.ph]  <= ahb_i.hwdata[SET_W-1:0];
        RMSU_K_AMODE: amode_reg            <= ahb_i.hwdata[MODE_W-1:0];
        RMSU_K_VMODE: vmode_reg            <= ahb_i.hwdata[MODE_W-1:0];
        RMSU_K_TRIM:  trim_reg             <= ahb_i.hwdata[TRIM_W-1:0];
        default:      trim_reg             <= trim_reg;
      endcase
    end
  end

  // Square and low-pass filter every channel; 0..2 current, 3..5 voltage.
  logic [SQ_W-1:0] sq     [6];
  logic [SQ_W-1:0] lp_reg [6];

  for (genvar p = 0; p < 3; p++) begin : g_phase
    logic signed [CUR_W-1:0]         ci;
    logic signed [VOLT_W-1:0]        vi;
    logic signed [VOLT_W+SET_W-1:0]  vprod;
    logic signed [VOLT_W+1:0]        vg;
    logic signed [2*VOLT_W+3:0]      vsq;
    assign ci    = smp_i.cur[p];
    assign vi    = smp_i.volt[p];
    assign vprod = vi * $signed(vmult_reg[p]);
    // Gain is applied ahead of squaring so it reaches the rms result.
    assign vg    = v_gain_on ? 18'(vi) + 18'(vprod >>> GAIN_SH) : 18'(vi);
    assign vsq   = vg * vg;
    assign sq[p]     = SQ_W'(ci) * SQ_W'(ci);
    assign sq[p + 3] = SQ_W'(unsigned'(vsq));
  end

  for (genvar c = 0; c < 6; c++) begin : g_lpf
    logic signed [SQ_W:0] diff;
    assign diff = $signed({1'b0, sq[c]}) - $signed({1'b0, lp_reg[c]});
    always_ff @(posedge mclk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
        lp_reg[c] <= '0;
      end else if (smp_i.valid) begin
        lp_reg[c] <= SQ_W'($signed({1'b0, lp_reg[c]}) + (diff >>> LPF_SH));
      end
    end
  end

  // Twelve slots: even slot takes the root, odd slot stores the result.
  logic [SLOT_W-1:0] slot_reg;
  logic [2:0]        chan;
  logic [1:0]        ph;
  logic              store;

  assign chan  = slot_reg[3:1];
  assign ph    = (chan >= 3'h3) ? 2'(chan - 3'h3) : chan[1:0];
  assign store = slot_reg[0];

  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      slot_reg <= 4'h0;
    end else begin
      slot_reg <= (slot_reg == UPDATE_DIV_M1) ? 4'h0 : slot_reg + 4'h1;
    end
  end

  // Current path corrects the mean square; voltage path corrects the root.
  logic signed [61:0] cwide;
  logic [SQ_W-1:0]    radicand;
  logic [RMS_W-1:0]   root_reg;
  logic [SQ_W-1:0]    lp_sel;

  assign lp_sel = lp_reg[chan];

  always_comb begin
    cwide = $signed({14'h0000, lp_reg[ph]});
    if (a_gain_on) begin
      // Scaling the square by the gain scales the root by its square root.
      cwide = cwide + ((cwide * 62'(signed'(pgain_reg[ph]))) >>> GAIN_SH);
    end
    cwide = cwide + (62'(signed'(ioff_reg[ph])) <<< CUR_OFF_SH);
    if (cwide < 0) begin
      radicand = '0;
    end else if (cwide > 62'(48'hFFFFFFFFFFFF)) begin
      radicand = 48'hFFFFFFFFFFFF;
    end else begin
      radicand = cwide[SQ_W-1:0];
    end
    if (chan >= 3'h3) begin
      radicand = {lp_sel[31:0], 16'h0000};
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      root_reg <= RST_RMS;
    end else if (!store) begin
      root_reg <= isqrt(radicand);
    end
  end

  logic signed [RMS_W+1:0] vwide;
  assign vwide = $signed({2'b00, root_reg}) + (26'(signed'(voff_reg[ph])) <<< VOLT_OFF_SH);

  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      for (int p = 0; p < 3; p++) begin
        irms_reg[p] <= RST_RMS;
        vrms_reg[p] <= RST_RMS;
      end
    end else if (store) begin
      if (chan < 3'h3) begin
        irms_reg[ph] <= root_reg;
      end else if (vwide < 0) begin
        vrms_reg[ph] <= RST_RMS;
      end else if (vwide[RMS_W+1:RMS_W] != 2'b00) begin
        vrms_reg[ph] <= 24'hFFFFFF;
      end else begin
        vrms_reg[ph] <= vwide[RMS_W-1:0];
      end
    end
  end

  // Checks.
  sequence s_cur_root;
    !store && chan < 3'h3;
  endsequence

  sequence s_volt_store;
    store && chan >= 3'h3;
  endsequence

  a_slot_wrap: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    slot_reg == UPDATE_DIV_M1 |=> slot_reg == 4'h0 ##1 slot_reg == 4'h1)
    else $error("slot counter does not wrap after 12");

  a_irms_hold: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    slot_reg != 4'h1 |=> $stable(irms_reg[0]))
    else $error("phase A current rms changed outside its slot");

  a_vrms_hold: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    slot_reg != 4'h7 |=> $stable(vrms_reg[0]))
    else $error("phase A voltage rms changed outside its slot");

  a_irms_store: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    s_cur_root ##1 store |=> irms_reg[$past(ph)] == $past(root_reg))
    else $error("current rms not stored from root");

  a_root_exact: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    s_cur_root |=> {24'h000000, root_reg} * {24'h000000, root_reg} <= $past(radicand)
      && ({25'h0, root_reg} + 49'h1) * ({25'h0, root_reg} + 49'h1) > {1'b0, $past(radicand)})
    else $error("current rms is not the root of the corrected square");

  a_vrms_offset: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    (s_volt_store and (vwide >= 0 && vwide[RMS_W+1:RMS_W] == 2'b00))
      |=> vrms_reg[$past(ph)] == $past(root_reg) + $past(24'(signed'(voff_reg[ph])) <<< 6))
    else $error("voltage rms offset not applied");

  a_vrms_clamp: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    (s_volt_store and (vwide < 0)) |=> vrms_reg[$past(ph)] == 24'h000000)
    else $error("negative voltage rms not clamped");

  a_lpf_follow: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    smp_i.valid && sq[0] <= lp_reg[0] |=> lp_reg[0] <= $past(lp_reg[0]))
    else $error("current filter rose above a smaller square");

  a_volt_scale: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    !store && chan >= 3'h3 |=> root_reg >= $past({8'h00, isqrt({16'h0000, lp_sel[31:0]})} << 8))
    else $error("voltage rms not scaled by 256");

  a_pgain_write: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    wr_pend_reg && wr_dec.kind == RMSU_K_PGAIN |=> pgain_reg[$past(wr_dec.ph)] == $past(ahb_i.hwdata[SET_W-1:0]))
    else $error("power gain setting not written");

  a_ioff_write: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    wr_pend_reg && wr_dec.kind == RMSU_K_IOFF |=> ioff_reg[$past(wr_dec.ph)] == $past(ahb_i.hwdata[SET_W-1:0]))
    else $error("current offset setting not written");

  a_cur_clamp: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    (s_cur_root and (cwide < 0)) |=> root_reg == 24'h000000)
    else $error("negative corrected current square not clamped");

  a_irms_b_hold: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    slot_reg != 4'h3 |=> $stable(irms_reg[1]))
    else $error("phase B current rms changed outside its slot");

  a_vrms_c_hold: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    slot_reg != 4'hB |=> $stable(vrms_reg[2]))
    else $error("phase C voltage rms changed outside its slot");

  a_slot_range: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    slot_reg <= UPDATE_DIV_M1)
    else $error("slot counter left its twelve slots");

  a_voltage_gain_setting_off: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    !v_gain_on |-> g_phase[0].vg == 18'(g_phase[0].vi))
    else $error("voltage gain applied outside modes 1 and 2");

  a_cur_gain_off: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    (s_cur_root and (!a_gain_on && ioff_reg[ph] == 12'h000)) |=> root_reg == $past(isqrt(lp_reg[ph])))
    else $error("current rms changed by gain outside modes 1 and 2");

  a_gain_raise: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    (s_cur_root and (a_gain_on && !pgain_reg[ph][SET_W-1] && ioff_reg[ph] == 12'h000))
      |=> root_reg >= $past(isqrt(lp_reg[ph])))
    else $error("positive power gain lowered current rms");

  a_gain_lower: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    (s_cur_root and (a_gain_on && pgain_reg[ph][SET_W-1] && ioff_reg[ph] == 12'h000))
      |=> root_reg <= $past(isqrt(lp_reg[ph])))
    else $error("negative power gain raised current rms");

  a_lpf_rise: assert property (
    @(posedge mclk_i) disable iff (!rst_n_reg)
    smp_i.valid && sq[0] >= lp_reg[0] |=> lp_reg[0] >= $past(lp_reg[0]))
    else $error("current filter fell below a larger square");

endmodule

// ---- tb/rmsu_src.sv ----
`timescale 1ns/100ps
module rmsu_src (
  // Clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              rst_n_i,
  // Levels to present on each strobe
  input  wire logic [2:0][rmsu_pkg::CUR_W-1:0]  cur_i,
  input  wire logic [2:0][rmsu_pkg::VOLT_W-1:0] volt_i,
  // Stream to the block
  output rmsu_pkg::rmsu_samples_t               smp_o
);
  import rmsu_pkg::*;
  logic [1:0] div_reg;
  // Between strobes the lines carry the inverse, so stale data never looks like a good sample.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= 2'h0;
      smp_o   <= '0;
    end else begin
      div_reg     <= div_reg + 2'h1;
      smp_o.valid <= (div_reg == 2'h3);
      smp_o.cur   <= (div_reg == 2'h3) ? cur_i : ~cur_i;
      smp_o.volt  <= (div_reg == 2'h3) ? volt_i : ~volt_i;
    end
  end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  import rmsu_pkg::*;
  typedef struct {logic [31:0] e; int tol;} rmsu_note_t;
  logic                   mclk_i, arst_n_i, hreadyout_o, hresp_o, rd_ph, hsel, hwrite;
  logic [31:0]            hrdata_o, haddr, hwdata, d;
  logic [1:0]             htrans;
  logic [2:0][CUR_W-1:0]  cur_lvl;
  logic [2:0][VOLT_W-1:0] volt_lvl;
  rmsu_samples_t          smp;
  rmsu_ahb_req_t          ahb;
  rmsu_note_t             notes[$];
  rmsu_note_t             nt;
  int                     fail_count, comparisons, am, vm;
  int                     ci[3], vi[3], pg[3], io[3], vg[3], vo[3];

  assign ahb = '{hsel:hsel, haddr:haddr, htrans:htrans, hwrite:hwrite, hsize:3'h2,
                 hwdata:hwdata, hready:hreadyout_o};

  rmsu_top uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .smp_i(smp), .ahb_i(ahb),
                .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o));
  rmsu_src src (.clk_i(mclk_i), .rst_n_i(arst_n_i), .cur_i(cur_lvl), .volt_i(volt_lvl), .smp_o(smp));

  task automatic results();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Read data is taken at the edge that ends the data phase.
  always @(posedge mclk_i) begin
    if (rd_ph && hreadyout_o) begin
      nt = notes.pop_front();
      d = (hrdata_o > nt.e) ? hrdata_o - nt.e : nt.e - hrdata_o;
      check("hrdata", (d <= nt.tol) ? nt.e : hrdata_o, nt.e);
      check("hresp", {31'h0, hresp_o}, 32'h0);
    end
  end

  task automatic waitrdy();
    int n;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      results();
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge mclk_i);
    hsel   <= 1'b1;
    haddr  <= {24'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    waitrdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rd_ph  <= !w;
    waitrdy();
    rd_ph  <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input int v);
    bus(1'b1, idx, 32'(v));
  endtask

  task automatic rd(input logic [5:0] idx, input int e, input int tol);
    notes.push_back('{32'(e), tol});
    bus(1'b0, idx, 32'h0);
  endtask

  function automatic int exp_i(int k);
    real s;
    s = real'(ci[k]) * ci[k];
    if (am == 1 || am == 2)
      s = s * (1.0 + pg[k] / 4096.0);
    s = s + io[k] * 32768.0;
    return (s < 0.0) ? 0 : int'($sqrt(s));
  endfunction

  function automatic int exp_v(int k);
    real r;
    r = 256.0 * ((vi[k] < 0) ? -vi[k] : vi[k]);
    if (vm == 1 || vm == 2)
      r = r * (1.0 + vg[k] / 4096.0);
    r = r + vo[k] * 64.0;
    return (r < 0.0) ? 0 : int'(r);
  endfunction

  // A large step needs well over a thousand strobes to settle, so the wait is long but fixed.
  task automatic apply();
    cur_lvl  <= {ci[2][CUR_W-1:0], ci[1][CUR_W-1:0], ci[0][CUR_W-1:0]};
    volt_lvl <= {vi[2][VOLT_W-1:0], vi[1][VOLT_W-1:0], vi[0][VOLT_W-1:0]};
    for (int k = 0; k < 3; k++) begin
      wr(IDX_PGAIN + 6'(k), pg[k]);
      wr(IDX_IOFF + 6'(k), io[k]);
      wr(IDX_VMULT + 6'(k), vg[k]);
      wr(IDX_VOFF + 6'(k), vo[k]);
      rd(IDX_PGAIN + 6'(k), pg[k] & 32'hFFF, 0);
      rd(IDX_IOFF + 6'(k), io[k] & 32'hFFF, 0);
    end
    wr(IDX_AMODE, am);
    wr(IDX_VMODE, vm);
    repeat (8000) @(posedge mclk_i);
    for (int k = 0; k < 3; k++) begin
      rd(IDX_IRMS + 6'(k), exp_i(k), exp_i(k) / 256 + 8);
      rd(IDX_VRMS + 6'(k), exp_v(k), exp_v(k) / 256 + 600);
    end
  endtask

  function automatic int rg();
    return int'($urandom_range(4095)) - 2048;
  endfunction

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  initial begin
    arst_n_i = 1'b0;
    {hsel, hwrite, rd_ph, htrans, haddr, hwdata} = '0;
    cur_lvl = '0;
    volt_lvl = '0;
    fail_count = 0;
    comparisons = 0;
    void'($urandom(32'h26AB662B));
    repeat (3) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    for (int i = 16; i < 42; i++)
      rd(6'(i), 0, 0);
    wr(IDX_TRIM, 32'h01F7);
    rd(IDX_TRIM, 32'h01F7, 0);
    wr(IDX_IRMS, 32'h00FFFFFF);
    rd(IDX_IRMS, 0, 0);
    wr(6'h3E, 32'h0000FFFF);
    rd(6'h3E, 0, 0);
    // Mode 0 must ignore the gains even though they are set.
    ci = '{1898124, -int'($urandom_range(2684354)), int'($urandom_range(2684354))};
    vi = '{7221, -int'($urandom_range(32767)), int'($urandom_range(32767))};
    pg = '{rg(), rg(), rg()};
    vg = '{rg(), rg(), rg()};
    io = '{0, 0, 0};
    vo = '{0, 0, 0};
    am = 0;
    vm = 0;
    apply();
    pg = '{2047, -2048, rg()};
    vg = '{2047, -2048, rg()};
    am = 1;
    vm = 2;
    apply();
    ci = '{2000, 1000, int'($urandom_range(2684354))};
    vi = '{100, int'($urandom_range(32767)), 100};
    io = '{-2048, 2047, 0};
    vo = '{-2048, 0, 100};
    am = 3;
    vm = 0;
    apply();
    // The two remaining gain modes, swapped between the paths.
    am = 2;
    vm = 1;
    apply();
    results();
  end
endmodule
